/* hw/lsc_lane_regs.sv */
// Functional notes
// R1: PLL multiplier code decodes to factors 4 to 65; four codes reserved.
// R2: Lane control register sits at address 0x07, resets to 0xDC04.
// R3: Output amplitude select in bits 14:12, reset 101, monotone levels.
// R4: Bit 11 enables loss-of-signal detection, resets to one.
// R5: Input lane enable bit 10, forced off by power-down pin or global bit.
// R6: In 2-to-1 mode input lanes 3 and 2 are disabled.
// R7: Bits 9:8 choose input lane rate: full, half, quarter, reserved.
// R8: Bits 7:4 choose output de-emphasis, reset zero meaning none.
// R9: Output lane enable bit 2, forced off by power-down pin or global bit.
// R10: In 1-to-2 mode output lanes 3 and 2 are disabled.
// R11: Bits 1:0 choose output lane rate: full, half, quarter, reserved.
// R12: Writes hit every masked lane; reads valid for a one-hot mask only.
// R13: PLL multiplier select in register 6 bits 3:0, resets to 0101.
// R14: Software keeps reserved bits and avoids reserved codes.
//
// Strobed register access was decided locally.
`include "lsc_defines.svh"

module lsc_lane_regs
  import lsc_pkg::*;
(
  input  wire logic                    core_clk_i,
  input  wire logic                    reset_i,
  input  wire logic [`LSC_ADDR_W-1:0]  reg_addr_i,
  input  wire logic [15:0]             reg_wdata_i,
  input  wire logic                    reg_write_i,
  input  wire logic                    reg_read_i,
  output logic      [15:0]             reg_rdata_o,
  input  wire logic                    channel_powerdown_n_i,
  output logic      [3:0]              input_lane_en_o,
  output logic      [3:0]              output_lane_en_o,
  output logic      [3:0]              signal_loss_detect_en_o,
  output logic      [11:0]             output_amplitude_sel_o,
  output logic      [7:0]              input_lane_rate_o,
  output logic      [15:0]             output_deemph_sel_o,
  output logic      [7:0]              output_lane_rate_o,
  output logic      [3:0]              pll_multiplier_sel_o,
  output logic      [`LSC_MPY_W-1:0]   pll_factor_x2_o,
  output logic                         pll_code_reserved_o,
  output logic                         read_invalid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    lsc_word_type [3:0] lane;
    logic [3:0]         lane_select_mask;
    logic               global_powerdown;
    logic               ser_2to1;
    logic               des_1to2;
    logic [3:0]         pll_multiplier_sel;
    logic [15:0]        rdata;
    logic               rd_invalid;
    logic [3:0]         in_en;
    logic [3:0]         out_en;
    logic               pd_meta;
    logic               pd_sync;
  } lsc_state_type;

  lsc_state_type state;
  lsc_state_type next_state;
  logic [3:0]    gate_in_en;
  logic [3:0]    gate_out_en;
  logic          powered_down;
  logic          mask_one_hot;
  logic [15:0]   sel_word;

  ////////////////////////////////////////////////////////////////////////////
  // Lane gates

  genvar g;
  generate
    for (g = 0; g < `LSC_NUM_LANES; g++)
    begin : gen_lane
      lsc_lane_if lane_bus ();
      assign lane_bus.settings = state.lane[g];
      // R5: input lanes forced off on power-down
      // R6: upper input lanes off in 2-to-1
      assign lane_bus.lane_forced_off_in  = powered_down | (state.ser_2to1 && g >= 2);
      // R9: output lanes forced off on power-down
      // R10: upper output lanes off in 1-to-2
      assign lane_bus.lane_forced_off_out = powered_down | (state.des_1to2 && g >= 2);
      assign gate_in_en[g]  = lane_bus.input_lane_en;
      assign gate_out_en[g] = lane_bus.output_lane_en;
      lsc_lane_gate u_gate
      (
        .lane (lane_bus.gate)
      );
    end
  endgenerate

  // R1: multiplier decode
  lsc_mpy_decode u_mpy
  (
    .pll_multiplier_sel_i (state.pll_multiplier_sel),
    .factor_x2_o          (pll_factor_x2_o),
    .reserved_o           (pll_code_reserved_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  assign powered_down = ~state.pd_sync | state.global_powerdown;
  assign mask_one_hot = $onehot(state.lane_select_mask);

  // Settings word of the single selected lane
  always_comb
  begin
    sel_word = 16'h0000;
    for (int i = 0; i < `LSC_NUM_LANES; i++)
    begin
      if (state.lane_select_mask == 4'(1 << i))
      begin
        sel_word = state.lane[i];
      end
    end
  end

  // Next value of every state field, register accesses included
  always_comb
  begin
    next_state          = state;
    next_state.pd_meta  = channel_powerdown_n_i;
    next_state.pd_sync  = state.pd_meta;
    next_state.in_en    = gate_in_en;
    next_state.out_en   = gate_out_en;
    next_state.rd_invalid = 1'b0;
    next_state.rdata    = 16'h0000;
    if (reg_write_i)
    begin
      unique case (reg_addr_i)
        // R2: lane control at 0x07
        `LSC_OFF_LANE_CTRL:
        begin
          // R12: write every masked lane
          for (int i = 0; i < `LSC_NUM_LANES; i++)
          begin
            if (state.lane_select_mask[i])
            begin
              next_state.lane[i] = reg_wdata_i;
            end
          end
        end
        // R13: multiplier in register 6
        `LSC_OFF_PLL:
        begin
          next_state.lane_select_mask   = reg_wdata_i[`LSC_MASK_HI:`LSC_MASK_LO];
          next_state.pll_multiplier_sel = reg_wdata_i[`LSC_MPY_SEL_HI:`LSC_MPY_SEL_LO];
        end
        `LSC_OFF_GLOBAL:
        begin
          next_state.global_powerdown = reg_wdata_i[`LSC_GLOBAL_PD_BIT];
        end
        `LSC_OFF_MODE:
        begin
          next_state.ser_2to1 = reg_wdata_i[`LSC_MODE_SER_BIT];
          next_state.des_1to2 = reg_wdata_i[`LSC_MODE_DES_BIT];
        end
        default:
        begin
        end
      endcase
    end
    if (reg_read_i)
    begin
      unique case (reg_addr_i)
        // R12: read of the one selected lane
        `LSC_OFF_LANE_CTRL:
        begin
          next_state.rdata      = sel_word;
          next_state.rd_invalid = ~mask_one_hot;
        end
        `LSC_OFF_PLL:
        begin
          next_state.rdata = {state.lane_select_mask, 8'h00, state.pll_multiplier_sel};
        end
        `LSC_OFF_GLOBAL:
        begin
          next_state.rdata = {state.global_powerdown, 15'h0000};
        end
        `LSC_OFF_MODE:
        begin
          next_state.rdata = {state.in_en, state.out_en, 6'h00, state.des_1to2, state.ser_2to1};
        end
        default:
        begin
          next_state.rdata = 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      // R2: lane reset word
      state.lane               <= {4{`LSC_LANE_RESET}};
      state.lane_select_mask   <= `LSC_MASK_RESET;
      state.global_powerdown   <= 1'b0;
      state.ser_2to1           <= 1'b0;
      state.des_1to2           <= 1'b0;
      // R13: multiplier reset code
      state.pll_multiplier_sel <= `LSC_PLL_RESET;
      state.rdata              <= 16'h0000;
      state.rd_invalid         <= 1'b0;
      state.in_en              <= 4'h0;
      state.out_en             <= 4'h0;
      state.pd_meta            <= 1'b0;
      state.pd_sync            <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign reg_rdata_o          = state.rdata;
  assign read_invalid_o       = state.rd_invalid;
  assign input_lane_en_o      = state.in_en;
  assign output_lane_en_o     = state.out_en;
  assign pll_multiplier_sel_o = state.pll_multiplier_sel;

  // Per-lane field fan-out
  always_comb
  begin
    for (int i = 0; i < `LSC_NUM_LANES; i++)
    begin
      // R3: amplitude field
      output_amplitude_sel_o[i*3 +: 3]  = state.lane[i][`LSC_AMP_HI:`LSC_AMP_LO];
      // R4: loss-of-signal enable
      signal_loss_detect_en_o[i]        = state.lane[i][`LSC_LOS_BIT];
      // R7: input rate
      input_lane_rate_o[i*2 +: 2]       = state.lane[i][`LSC_IN_RATE_HI:`LSC_IN_RATE_LO];
      // R8: de-emphasis field
      output_deemph_sel_o[i*4 +: 4]     = state.lane[i][`LSC_DE_HI:`LSC_DE_LO];
      // R11: output rate
      output_lane_rate_o[i*2 +: 2]      = state.lane[i][`LSC_OUT_RATE_HI:`LSC_OUT_RATE_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  sequence s_lane_write(int unsigned k);
    reg_write_i && reg_addr_i == `LSC_OFF_LANE_CTRL && state.lane_select_mask[k];
  endsequence

  property p_mpy_ten;
    @(posedge core_clk_i) disable iff (reset_i)
      state.pll_multiplier_sel == 4'h5 |-> pll_factor_x2_o == 8'h14 && !pll_code_reserved_o;
  endproperty
  a_mpy_ten: assert property (p_mpy_ten) else $error("multiplier decode wrong"); // R1

  property p_write_lane0;
    @(posedge core_clk_i) disable iff (reset_i)
      s_lane_write(0) |=> state.lane[0] == $past(reg_wdata_i);
  endproperty
  a_write_lane0: assert property (p_write_lane0) else $error("lane 0 not written"); // R12

  property p_nowrite_lane3;
    @(posedge core_clk_i) disable iff (reset_i)
      reg_write_i && !state.lane_select_mask[3] |=> $stable(state.lane[3]);
  endproperty
  a_nowrite_lane3: assert property (p_nowrite_lane3) else $error("unmasked lane changed"); // R12

  property p_read_back;
    @(posedge core_clk_i) disable iff (reset_i)
      reg_read_i && reg_addr_i == `LSC_OFF_LANE_CTRL && state.lane_select_mask == 4'h2
      |=> reg_rdata_o == $past(state.lane[1]) && !read_invalid_o;
  endproperty
  a_read_back: assert property (p_read_back) else $error("lane read wrong"); // R12

  property p_pd_in;
    @(posedge core_clk_i) disable iff (reset_i)
      state.global_powerdown |=> input_lane_en_o == 4'h0;
  endproperty
  a_pd_in: assert property (p_pd_in) else $error("input lane on in power-down"); // R5

  property p_pd_out;
    @(posedge core_clk_i) disable iff (reset_i)
      !state.pd_sync |=> output_lane_en_o == 4'h0;
  endproperty
  a_pd_out: assert property (p_pd_out) else $error("output lane on in power-down"); // R9

  property p_ser_mode;
    @(posedge core_clk_i) disable iff (reset_i)
      state.ser_2to1 |=> input_lane_en_o[3:2] == 2'b00;
  endproperty
  a_ser_mode: assert property (p_ser_mode) else $error("upper input lanes on in 2-to-1"); // R6

  property p_des_mode;
    @(posedge core_clk_i) disable iff (reset_i)
      state.des_1to2 |=> output_lane_en_o[3:2] == 2'b00;
  endproperty
  a_des_mode: assert property (p_des_mode) else $error("upper output lanes on in 1-to-2"); // R10

  property p_fields;
    @(posedge core_clk_i) disable iff (reset_i)
      signal_loss_detect_en_o[0] == state.lane[0][`LSC_LOS_BIT]
      && output_amplitude_sel_o[2:0] == state.lane[0][`LSC_AMP_HI:`LSC_AMP_LO]
      && input_lane_rate_o[1:0] == state.lane[0][`LSC_IN_RATE_HI:`LSC_IN_RATE_LO]
      && output_deemph_sel_o[3:0] == state.lane[0][`LSC_DE_HI:`LSC_DE_LO]
      && output_lane_rate_o[1:0] == state.lane[0][`LSC_OUT_RATE_HI:`LSC_OUT_RATE_LO];
  endproperty
  a_fields: assert property (p_fields) else $error("lane field mapping wrong"); // R3

endmodule

/* hw/lsc_defines.svh */
// Register offsets, field positions and reset values of the lane control block
`ifndef LSC_DEFINES_SVH
`define LSC_DEFINES_SVH

`define LSC_ADDR_W         5
`define LSC_DATA_W         16
`define LSC_NUM_LANES      4
`define LSC_OFF_GLOBAL     5'h01
`define LSC_OFF_PLL        5'h06
`define LSC_OFF_LANE_CTRL  5'h07
`define LSC_OFF_MODE       5'h1E
`define LSC_GLOBAL_PD_BIT  15
`define LSC_LANE_RESET     16'hDC04
`define LSC_LANE_RSV_MASK  16'h8008
`define LSC_LANE_RSV_VAL   16'h8000
`define LSC_PLL_RESET      4'h5
`define LSC_AMP_HI         14
`define LSC_AMP_LO         12
`define LSC_LOS_BIT        11
`define LSC_IN_EN_BIT      10
`define LSC_IN_RATE_HI     9
`define LSC_IN_RATE_LO     8
`define LSC_DE_HI          7
`define LSC_DE_LO          4
`define LSC_OUT_EN_BIT     2
`define LSC_OUT_RATE_HI    1
`define LSC_OUT_RATE_LO    0
`define LSC_MASK_HI        15
`define LSC_MASK_LO        12
`define LSC_MASK_RESET     4'h1
`define LSC_MPY_SEL_HI     3
`define LSC_MPY_SEL_LO     0
`define LSC_MODE_SER_BIT   0
`define LSC_MODE_DES_BIT   1
// PLL factor is given in half steps: factor times two
`define LSC_MPY_W          8

`endif

/* hw/lsc_pkg.sv */
// Types shared by the lane control block
package lsc_pkg;
  typedef logic [1:0] lsc_rate_type;
  typedef logic [15:0] lsc_word_type;
endpackage

/* hw/lsc_lane_if.sv */
// Per-lane settings carried from the register bank to each lane gate
interface lsc_lane_if;
  logic [15:0] settings;
  logic        lane_forced_off_in;
  logic        lane_forced_off_out;
  logic        input_lane_en;
  logic        output_lane_en;

  modport bank
  (
    output settings,
    output lane_forced_off_in,
    output lane_forced_off_out,
    input  input_lane_en,
    input  output_lane_en
  );
  modport gate
  (
    input  settings,
    input  lane_forced_off_in,
    input  lane_forced_off_out,
    output input_lane_en,
    output output_lane_en
  );
endinterface

/* hw/lsc_lane_gate.sv */
// Effective enables of one lane after power-down and mux-mode overrides
`include "lsc_defines.svh"

module lsc_lane_gate
  import lsc_pkg::*;
(
  lsc_lane_if.gate lane
);
  // Register bit qualified by the forcing terms
  assign lane.input_lane_en  = lane.settings[`LSC_IN_EN_BIT] & ~lane.lane_forced_off_in;
  assign lane.output_lane_en = lane.settings[`LSC_OUT_EN_BIT] & ~lane.lane_forced_off_out;
endmodule

/* hw/lsc_mpy_decode.sv */
// Decoder of the low-speed PLL multiplier select
`include "lsc_defines.svh"

module lsc_mpy_decode
  import lsc_pkg::*;
(
  input  wire logic [3:0]             pll_multiplier_sel_i,
  output logic      [`LSC_MPY_W-1:0]  factor_x2_o,
  output logic                        reserved_o
);
  // R1: code to factor table
  always_comb
  begin
    reserved_o  = 1'b0;
    factor_x2_o = 8'h00;
    unique case (pll_multiplier_sel_i)
      4'h0: factor_x2_o = 8'h08;
      4'h1: factor_x2_o = 8'h0A;
      4'h2: factor_x2_o = 8'h0C;
      4'h4: factor_x2_o = 8'h10;
      4'h5: factor_x2_o = 8'h14;
      4'h6: factor_x2_o = 8'h18;
      4'h7: factor_x2_o = 8'h19;
      4'h8: factor_x2_o = 8'h1E;
      4'h9: factor_x2_o = 8'h28;
      4'hA: factor_x2_o = 8'h32;
      4'hD: factor_x2_o = 8'h64;
      4'hE: factor_x2_o = 8'h82;
      default: reserved_o = 1'b1;
    endcase
  end
endmodule

/* sim/lsc_lane_regs_tb.sv */
// Self-checking testbench of the lane control register block
`include "lsc_defines.svh"

module lsc_lane_regs_tb
  import lsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic                    core_clk_i;
  logic                    reset_i;
  logic [`LSC_ADDR_W-1:0]  reg_addr_i;
  logic [15:0]             reg_wdata_i;
  logic                    reg_write_i;
  logic                    reg_read_i;
  logic [15:0]             reg_rdata_o;
  logic                    channel_powerdown_n_i;
  logic [3:0]              input_lane_en_o;
  logic [3:0]              output_lane_en_o;
  logic [3:0]              signal_loss_detect_en_o;
  logic [11:0]             output_amplitude_sel_o;
  logic [7:0]              input_lane_rate_o;
  logic [15:0]             output_deemph_sel_o;
  logic [7:0]              output_lane_rate_o;
  logic [3:0]              pll_multiplier_sel_o;
  logic [`LSC_MPY_W-1:0]   pll_factor_x2_o;
  logic                    pll_code_reserved_o;
  logic                    read_invalid_o;
  int                      fail_count;
  int                      compares;
  logic [15:0]             d;
  logic                    v;
  // Expected multiplier factors times two, zero where the code is reserved
  logic [7:0]              factor_x2 [16] = '{8'h08, 8'h0A, 8'h0C, 8'h00, 8'h10, 8'h14, 8'h18,
                                              8'h19, 8'h1E, 8'h28, 8'h32, 8'h00, 8'h00, 8'h64,
                                              8'h82, 8'h00};
  logic [15:0]             rsv_codes = 16'h9808;

  lsc_lane_regs lsc_lane_regs_inst
  (
    .core_clk_i              (core_clk_i),
    .reset_i                 (reset_i),
    .reg_addr_i              (reg_addr_i),
    .reg_wdata_i             (reg_wdata_i),
    .reg_write_i             (reg_write_i),
    .reg_read_i              (reg_read_i),
    .reg_rdata_o             (reg_rdata_o),
    .channel_powerdown_n_i   (channel_powerdown_n_i),
    .input_lane_en_o         (input_lane_en_o),
    .output_lane_en_o        (output_lane_en_o),
    .signal_loss_detect_en_o (signal_loss_detect_en_o),
    .output_amplitude_sel_o  (output_amplitude_sel_o),
    .input_lane_rate_o       (input_lane_rate_o),
    .output_deemph_sel_o     (output_deemph_sel_o),
    .output_lane_rate_o      (output_lane_rate_o),
    .pll_multiplier_sel_o    (pll_multiplier_sel_o),
    .pll_factor_x2_o         (pll_factor_x2_o),
    .pll_code_reserved_o     (pll_code_reserved_o),
    .read_invalid_o          (read_invalid_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock of 50 ns period
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [4:0] addr, input logic [15:0] data);
    @(posedge core_clk_i);
    reg_addr_i  <= addr;
    reg_wdata_i <= data;
    reg_write_i <= 1'b1;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [4:0] addr, output logic [15:0] data, output logic inv);
    @(posedge core_clk_i);
    reg_addr_i <= addr;
    reg_read_i <= 1'b1;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1;
    data = reg_rdata_o;
    inv  = read_invalid_o;
  endtask

  // Bounded wait for the effective lane enables
  task automatic wait_en(input logic [3:0] ein, input logic [3:0] eout);
    int n;
    n = 0;
    while ((input_lane_en_o !== ein || output_lane_en_o !== eout) && n < 10)
    begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    check("input_lane_en", 16'(input_lane_en_o), 16'(ein));
    check("output_lane_en", 16'(output_lane_en_o), 16'(eout));
    // Enables never settled: the mismatch is counted, end the run
    if (input_lane_en_o !== ein || output_lane_en_o !== eout)
    begin
      results();
    end
  endtask

  // Verdict and end of run
  task automatic results();
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    fail_count = 0;
    compares = 0;
    reset_i = 1'b1;
    reg_addr_i = 5'h00;
    reg_wdata_i = 16'h0000;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    channel_powerdown_n_i = 1'b1;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    // Reset values of both registers and all lane fields
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'hDC04);
    check("read_invalid", 16'(v), 16'h0000);
    @(posedge core_clk_i);
    #1;
    check("rdata_idle", reg_rdata_o, 16'h0000);
    rd(`LSC_OFF_PLL, d, v);
    check("pll_reg", d & 16'hF00F, 16'h1005);
    check("amplitude", 16'(output_amplitude_sel_o), 16'h0B6D);
    check("loss_detect", 16'(signal_loss_detect_en_o), 16'h000F);
    check("in_rate", 16'(input_lane_rate_o), 16'h0000);
    check("deemph", output_deemph_sel_o, 16'h0000);
    check("out_rate", 16'(output_lane_rate_o), 16'h0000);
    wait_en(4'hF, 4'hF);
    // Power-down pin and global power-down bit
    @(posedge core_clk_i);
    channel_powerdown_n_i <= 1'b0;
    wait_en(4'h0, 4'h0);
    @(posedge core_clk_i);
    channel_powerdown_n_i <= 1'b1;
    wait_en(4'hF, 4'hF);
    wr(`LSC_OFF_GLOBAL, 16'h8000);
    wait_en(4'h0, 4'h0);
    wr(`LSC_OFF_GLOBAL, 16'h0000);
    wait_en(4'hF, 4'hF);
    // Mux modes switch off lanes 3 and 2
    wr(`LSC_OFF_MODE, 16'h0001);
    wait_en(4'h3, 4'hF);
    wr(`LSC_OFF_MODE, 16'h0002);
    wait_en(4'hF, 4'h3);
    rd(`LSC_OFF_MODE, d, v);
    check("mode_reg", d, 16'hF302);
    wr(`LSC_OFF_MODE, 16'h0000);
    wait_en(4'hF, 4'hF);
    // Every multiplier code
    for (int c = 0; c < 16; c++)
    begin
      wr(`LSC_OFF_PLL, 16'h1000 | 16'(c));
      check("pll_sel", 16'(pll_multiplier_sel_o), 16'(c));
      check("pll_reserved", 16'(pll_code_reserved_o), 16'(rsv_codes[c]));
      if (!rsv_codes[c])
        check("pll_factor", 16'(pll_factor_x2_o), 16'(factor_x2[c]));
    end
    // Two-lane write, then per-lane readback
    // reserved bits kept
    wr(`LSC_OFF_PLL, 16'h3005);
    wr(`LSC_OFF_LANE_CTRL, 16'hA1A6);
    check("amplitude", 16'(output_amplitude_sel_o), 16'h0B52);
    check("loss_detect", 16'(signal_loss_detect_en_o), 16'h000C);
    check("in_rate", 16'(input_lane_rate_o), 16'h0005);
    check("deemph", output_deemph_sel_o, 16'h00AA);
    check("out_rate", 16'(output_lane_rate_o), 16'h000A);
    wait_en(4'hC, 4'hF);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'h0000);
    check("read_invalid", 16'(v), 16'h0001);
    wr(`LSC_OFF_PLL, 16'h2005);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'hA1A6);
    check("read_invalid", 16'(v), 16'h0000);
    wr(`LSC_OFF_PLL, 16'h4005);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'hDC04);
    wr(`LSC_OFF_PLL, 16'h0005);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("read_invalid", 16'(v), 16'h0001);
    // Unmapped place: write ignored, read gives zero
    wr(5'h10, 16'hFFFF);
    rd(5'h10, d, v);
    check("unmapped", d, 16'h0000);
    wr(`LSC_OFF_PLL, 16'h1005);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'hA1A6);
    // Reset in mid-run restores lane 1 to the reset word
    @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    reset_i <= 1'b0;
    wr(`LSC_OFF_PLL, 16'h2005);
    rd(`LSC_OFF_LANE_CTRL, d, v);
    check("lane_reg", d, 16'hDC04);
    results();
  end

endmodule
